// ===== rtl/diag_limit_check.sv
// Compares one monitored value against its limits.
// Assumes a guard band of two counts for the warning level.
`timescale 1ns/1ps
module diag_limit_check (
    diag_mon_if.cmp mon
);
    always_comb begin
        mon.flags[1] = (mon.value > mon.hi_limit) || (mon.value < mon.lo_limit); // R12
        mon.flags[0] = (mon.value > mon.hi_limit - 8'h02) || (mon.value < mon.lo_limit + 8'h02); // R12
    end
endmodule

// ===== rtl/diag_mon_if.sv
// Carries one monitored value and its limits to the comparator.
// Assumes the top module fills it each clock.
`timescale 1ns/1ps
interface diag_mon_if;
    logic [7:0] value;
    logic [7:0] lo_limit;
    logic [7:0] hi_limit;
    logic [1:0] flags;
    modport src (output value, output lo_limit, output hi_limit, input flags);
    modport cmp (input value, input lo_limit, input hi_limit, output flags);
endinterface

// ===== rtl/diag_pkg.sv
// Constants for the two-wire diagnostics target.
// Assumes one 100 MHz clock and an asynchronous active-high reset.
// Notes on behaviour
// R01: Power-down high holds the module in low-power state.
// R02: Power-down falling edge fully resets module, serial logic included; code clears phase, sda_oe, sda_out, ptr, bitn, first; mem keeps its bytes.
// R03: No reference clock needed; reference clock pair is ignored.
// R04: Host alone drives the serial clock; module never drives it.
// R05: Data bits captured on clock rise; writes skip protected bytes.
// R06: Read data bits change on clock falling edges.
// R07: Data line is shared; the idle party releases it.
// R08: Host marks start and stop with data changes while clock high.
// R09: Memory is byte-wide, bytes reached singly or in runs.
// R10: Random and sequential access from address zero to the top.
// R11: Five monitored values readable in real time.
// R12: Alarm and warning flags set when a value leaves its limits.
// R13: Address pointer advances by one after each byte.
package diag_pkg;
    localparam int ADDR_W = 8;
    localparam logic [6:0] DEV_ADDR = 7'h50;
    localparam logic [ADDR_W-1:0] WP_TOP = 8'h7F;
    localparam logic [ADDR_W-1:0] MON_BASE = 8'h60;
    localparam logic [ADDR_W-1:0] FLAG_BASE = 8'h50;
    localparam int NUM_MON = 5;
    localparam int BIT_LAST = 7;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK = 3'b010,
        ST_WR = 3'b011,
        ST_RD = 3'b100,
        ST_RACK = 3'b101
    } phase_t;
endpackage

// ===== rtl/diag_two_wire_target.sv
// Two-wire serial target over the diagnostics memory.
// Assumes scl and sda arrive asynchronously and pass two flip-flops.
`timescale 1ns/1ps
module diag_two_wire_target
    import diag_pkg::*;
#(
    parameter int DEPTH = 256
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic power_down,
    input wire logic ref_clock_in_pos, // R03
    input wire logic ref_clock_in_neg, // R03
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic low_power,
    input wire logic [7:0] mon_value [NUM_MON],
    input wire logic [7:0] mon_lo [NUM_MON],
    input wire logic [7:0] mon_hi [NUM_MON]
);
    if (DEPTH != 2 ** ADDR_W) begin : gen_bad_depth
        $error("DEPTH must match the pointer width");
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic [1:0] pd_s;
        logic scl_d;
        logic sda_d;
        logic pd_d;
        phase_t phase;
        logic [2:0] bitn;
        logic [7:0] shift;
        logic first;
        logic rw;
        logic [ADDR_W-1:0] ptr;
        logic sda_out;
        logic sda_oe;
        logic low_power;
        logic [7:0] wdata;
        logic wen;
        logic [ADDR_W-1:0] waddr;
    } state_t;

    state_t s, n;
    logic [7:0] mem [DEPTH];
    logic [7:0] rd_byte;
    logic [1:0] mon_flags [NUM_MON];
    logic [7:0] flag_byte;
    logic scl, sda, rise, fall, start_c, stop_c, pd_fall;
    diag_mon_if mif [NUM_MON] ();

    // ----------------------------------------
    // Monitor comparators
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_MON; g++) begin : gen_mon
            assign mif[g].value = mon_value[g];
            assign mif[g].lo_limit = mon_lo[g];
            assign mif[g].hi_limit = mon_hi[g];
            assign mon_flags[g] = mif[g].flags;
            diag_limit_check u_chk (.mon(mif[g]));
        end
    endgenerate

    always_comb begin
        flag_byte = '0;
        for (int i = 0; i < NUM_MON; i++) begin
            flag_byte[i] = mon_flags[i][1];
        end
    end

    // Reads: live values and flags, else stored bytes
    always_comb begin
        rd_byte = mem[s.ptr];
        if (s.ptr >= MON_BASE && s.ptr < MON_BASE + 8'(NUM_MON)) begin
            rd_byte = mon_value[3'(s.ptr - MON_BASE)]; // R11
        end else if (s.ptr == FLAG_BASE) begin
            rd_byte = flag_byte; // R12
        end else if (s.ptr == FLAG_BASE + 8'h01) begin
            rd_byte = {3'h0, mon_flags[4][0], mon_flags[3][0], mon_flags[2][0], mon_flags[1][0],
                mon_flags[0][0]}; // R12
        end
    end

    // ----------------------------------------
    // Edge and condition detection
    // ----------------------------------------
    always_comb begin
        scl = s.scl_s[1];
        sda = s.sda_s[1];
        rise = scl && !s.scl_d;
        fall = !scl && s.scl_d;
        start_c = scl && s.scl_d && s.sda_d && !sda; // R08
        stop_c = scl && s.scl_d && !s.sda_d && sda; // R08
        pd_fall = s.pd_d && !s.pd_s[1]; // R02
    end

    // ----------------------------------------
    // Protocol engine
    // ----------------------------------------
    always_comb begin
        n = s;
        n.scl_s = {s.scl_s[0], scl_in}; // R04
        n.sda_s = {s.sda_s[0], sda_in};
        n.pd_s = {s.pd_s[0], power_down};
        n.scl_d = scl;
        n.sda_d = sda;
        n.pd_d = s.pd_s[1];
        n.low_power = s.pd_s[1]; // R01
        n.wen = 1'b0;
        if (s.pd_s[1] || pd_fall) begin
            n.phase = ST_IDLE; // R01 R02
            n.sda_oe = 1'b0;
            n.sda_out = 1'b0;
            n.ptr = '0;
            n.bitn = '0;
            n.first = 1'b0;
        end else if (start_c) begin
            n.phase = ST_ADDR;
            n.bitn = '0;
            n.first = 1'b1;
            n.sda_oe = 1'b0;
        end else if (stop_c) begin
            n.phase = ST_IDLE;
            n.sda_oe = 1'b0;
        end else begin
            case (s.phase)
                ST_IDLE: begin
                    n.sda_oe = 1'b0;
                end
                ST_ADDR, ST_WR: begin
                    if (rise) begin
                        n.shift = {s.shift[6:0], sda}; // R05
                        n.bitn = s.bitn + 3'h1;
                        if (s.bitn == 3'(BIT_LAST)) begin
                            n.phase = ST_ACK;
                        end
                    end
                end
                ST_ACK: begin
                    if (fall && !s.sda_oe) begin
                        if (s.first && s.shift[7:1] != DEV_ADDR) begin
                            n.phase = ST_IDLE;
                        end else begin
                            n.sda_oe = 1'b1; // R07
                            n.sda_out = 1'b0;
                        end
                    end else if (fall && s.sda_oe) begin
                        n.sda_oe = 1'b0; // R07
                        if (s.first) begin
                            n.first = 1'b0;
                            n.rw = s.shift[0];
                            n.phase = s.shift[0] ? ST_RD : ST_ADDR;
                            if (s.shift[0]) begin
                                n.sda_oe = !rd_byte[7]; // R06
                                n.sda_out = 1'b0;
                                n.shift = {rd_byte[6:0], 1'b0};
                            end else begin
                                n.rw = 1'b0;
                            end
                        end else if (s.phase == ST_ACK && !s.rw && s.wen == 1'b0 && s.bitn == 3'h0
                            && s.waddr == 8'hFF) begin
                            n.phase = ST_WR;
                        end else begin
                            n.phase = ST_WR;
                        end
                    end else if (rise && s.sda_oe && !s.first && s.rw == 1'b0) begin
                        // Address byte goes to pointer the first time, data after
                        if (s.waddr == 8'hFF) begin
                            n.ptr = s.shift; // R10
                            n.waddr = 8'h00;
                        end else begin
                            n.wen = (s.ptr > WP_TOP); // R05
                            n.wdata = s.shift;
                            n.waddr = s.ptr;
                            n.ptr = s.ptr + 8'h01; // R13
                        end
                    end else if (rise && s.sda_oe && s.first) begin
                        n.waddr = 8'hFF;
                    end
                end
                ST_RD: begin
                    if (fall) begin
                        n.bitn = s.bitn + 3'h1;
                        if (s.bitn == 3'(BIT_LAST)) begin
                            n.sda_oe = 1'b0;
                            n.phase = ST_RACK;
                            n.ptr = s.ptr + 8'h01; // R13
                        end else begin
                            n.sda_oe = !s.shift[7]; // R06 R07
                            n.shift = {s.shift[6:0], 1'b0};
                        end
                    end
                end
                ST_RACK: begin
                    if (rise) begin
                        n.first = sda;
                    end else if (fall) begin
                        if (s.first) begin
                            n.phase = ST_IDLE;
                        end else begin
                            n.phase = ST_RD; // R09
                            n.sda_oe = !rd_byte[7]; // R06
                            n.shift = {rd_byte[6:0], 1'b0};
                        end
                        n.first = 1'b0;
                    end
                end
                default: begin
                    n.phase = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // ----------------------------------------
    // Byte memory
    // ----------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= 8'h00;
            end
        end else if (s.wen) begin
            mem[s.waddr] <= s.wdata; // R09
        end
    end

    assign sda_out = s.sda_out;
    assign sda_oe = s.sda_oe;
    assign low_power = s.low_power;
endmodule

// ===== testbench/diag_two_wire_sva.sv
// Port checker for the two-wire diagnostics target.
// Assumes one clock mclk and asynchronous reset rst.
`timescale 1ns/1ps
module diag_two_wire_sva (
    input wire logic mclk,
    input wire logic rst,
    input wire logic power_down,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic low_power
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_pd_hold;
        power_down [*8];
    endsequence
    sequence s_scl_idle;
        scl_in [*8] ##1 scl_in [*8];
    endsequence
    property p_enter_low;
        $rose(power_down) |-> ##[1:5] low_power;
    endproperty
    a_enter_low: assert property (p_enter_low) else $error("low power not entered");
    property p_leave_low;
        $fell(power_down) |-> ##[1:5] !low_power;
    endproperty
    a_leave_low: assert property (p_leave_low) else $error("low power not left");
    property p_pd_idle;
        s_pd_hold |-> !sda_oe;
    endproperty
    a_pd_idle: assert property (p_pd_idle) else $error("data driven in power down");
    property p_rst_quiet;
        $fell(rst) |-> !sda_oe && !low_power;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
    property p_drive_low;
        sda_oe |-> !sda_out;
    endproperty
    a_drive_low: assert property (p_drive_low) else $error("data line driven high");
    property p_oe_fall;
        $changed(sda_oe) |-> !scl_in && !$past(scl_in, 2);
    endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("data changed outside clock low");
    property p_oe_hold;
        $rose(scl_in) |-> $stable(sda_oe) [*8];
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("data moved while clock high");
    property p_idle_release;
        s_scl_idle |-> !sda_oe;
    endproperty
    a_idle_release: assert property (p_idle_release) else $error("data held on idle bus");
endmodule
bind diag_two_wire_target diag_two_wire_sva u_sva (.mclk(mclk), .rst(rst), .power_down(power_down),
    .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .low_power(low_power));

// ===== testbench/tb.sv
// Testbench for the two-wire diagnostics target.
// Assumes the host model and the port checker alongside.
`timescale 1ns/1ps
module tb;
    import diag_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, power_down = 1'b0, ref_p = 1'b0, ref_n = 1'b1;
    logic scl, sda_low, sda_oe, sda_out, low_power, ack;
    logic [7:0] d;
    logic [7:0] mon_value [NUM_MON], mon_lo [NUM_MON], mon_hi [NUM_MON];
    wire sda = !sda_low && !(sda_oe && !sda_out);
    int bad_count = 0, comparisons = 0, cycles = 0;
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        ref_p <= ~ref_p;
        ref_n <= ~ref_n;
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            bad_count++;
            results();
        end
    end
    two_wire_host host (.mclk(mclk), .scl(scl), .sda_low(sda_low), .sda(sda));
    diag_two_wire_target DUT (.mclk(mclk), .rst(rst), .power_down(power_down), .ref_clock_in_pos(ref_p),
        .ref_clock_in_neg(ref_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .low_power(low_power), .mon_value(mon_value), .mon_lo(mon_lo), .mon_hi(mon_hi));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    task automatic set_ptr(input logic [7:0] p);
        host.start();
        host.wbyte(8'hA0, ack);
        chk({7'h00, ack}, 8'h01, "address ack");
        host.wbyte(p, ack);
        chk({7'h00, ack}, 8'h01, "pointer ack");
    endtask
    task automatic t_seq_write_read();
        set_ptr(8'h80);
        host.wbyte(8'hA5, ack);
        host.wbyte(8'h3C, ack);
        chk({7'h00, ack}, 8'h01, "data ack");
        host.stop();
        set_ptr(8'h80);
        host.start();
        host.wbyte(8'hA1, ack);
        host.rbyte(d, 1'b1);
        chk(d, 8'hA5, "random read");
        host.rbyte(d, 1'b0);
        chk(d, 8'h3C, "sequential read");
        host.stop();
    endtask
    task automatic t_monitor();
        set_ptr(8'h60);
        host.wbyte(8'hDE, ack);
        chk({7'h00, ack}, 8'h01, "protected write ack");
        host.stop();
        set_ptr(8'h60);
        host.start();
        host.wbyte(8'hA1, ack);
        for (int i = 0; i < NUM_MON; i++) begin
            host.rbyte(d, i < NUM_MON - 1);
            chk(d, 8'h21 + 8'(i), "live value");
        end
        host.stop();
    endtask
    task automatic t_flags();
        set_ptr(8'h50);
        host.start();
        host.wbyte(8'hA1, ack);
        host.rbyte(d, 1'b1);
        chk(d, 8'h00, "alarm clear");
        host.rbyte(d, 1'b0);
        chk(d, 8'h00, "warning clear");
        host.stop();
        @(posedge mclk) mon_value[2] <= 8'hFF;
        set_ptr(8'h50);
        host.start();
        host.wbyte(8'hA1, ack);
        host.rbyte(d, 1'b0);
        chk(d, 8'h04, "alarm set");
        host.stop();
    endtask
    task automatic t_refused();
        host.start();
        host.wbyte(8'hA2, ack);
        chk({7'h00, ack}, 8'h00, "foreign address");
        host.stop();
    endtask
    task automatic t_power();
        set_ptr(8'h80);
        repeat (10) @(posedge mclk);
        power_down <= 1'b1;
        repeat (12) @(posedge mclk);
        chk({7'h00, low_power}, 8'h01, "low power");
        power_down <= 1'b0;
        repeat (12) @(posedge mclk);
        chk({7'h00, low_power}, 8'h00, "awake");
        host.start();
        host.wbyte(8'hA1, ack);
        chk({7'h00, ack}, 8'h01, "ack after reset");
        host.rbyte(d, 1'b0);
        chk(d, 8'h00, "pointer cleared");
        host.stop();
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        for (int i = 0; i < NUM_MON; i++) begin
            mon_value[i] = 8'h21 + 8'(i);
            mon_lo[i] = 8'h10;
            mon_hi[i] = 8'hF0;
        end
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        repeat (6) @(posedge mclk);
        chk({6'h00, sda_oe, low_power}, 8'h00, "reset state");
        t_seq_write_read();
        t_monitor();
        t_flags();
        t_refused();
        repeat (20) @(posedge mclk);
        t_power();
        results();
    end
endmodule

// ===== testbench/two_wire_host.sv
// Host controller model driving the serial clock and data.
// Assumes the data wire is resolved with a pull-up in the bench.
`timescale 1ns/1ps
module two_wire_host (
    input wire logic mclk,
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic start();
        @(negedge mclk);
        #20 sda_low = 1'b0;
        #20 scl = 1'b1;
        #40 sda_low = 1'b1;
        #40 scl = 1'b0;
    endtask
    task automatic stop();
        #40 sda_low = 1'b1;
        #40 scl = 1'b1;
        #40 sda_low = 1'b0;
        #40;
    endtask
    task automatic bit_io(input logic b, output logic r);
        #40 sda_low = !b;
        #40 scl = 1'b1;
        #40 r = sda;
        #40 scl = 1'b0;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(output logic [7:0] d, input logic more);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(!more, r);
    endtask
endmodule
